/* hw/ppcr_cfg_if.sv */
// interface: raw register bytes out, decoded protocol settings back
`timescale 1ns/100ps
interface ppcr_cfg_if;
  import ppcr_pkg::*;
  logic [7:0] proto;    // protocol control byte
  logic [7:0] txa;      // type-a option byte
  ppcr_fam_t  fam;      // decoded family
  ppcr_rate_t rx_rate;  // decoded receive rate
  ppcr_rate_t tx_rate;  // effective transmit rate
  logic       sel_ok;   // select code supported
  modport bank (output proto, txa,
                input fam, rx_rate, tx_rate, sel_ok);
  modport dec (input proto, txa,
               output fam, rx_rate, tx_rate, sel_ok);
endinterface // ppcr_cfg_if

/* hw/ppcr_decode.sv */
// module: registered decode of protocol select and transmit rate
`timescale 1ns/100ps
module ppcr_decode (
  input  wire logic SYS_CLK,
  input  wire logic RSTN,
  ppcr_cfg_if.dec   cfg
);
  import ppcr_pkg::*;

  ppcr_fam_t  next_fam;   // family from select code
  ppcr_rate_t next_rx;    // receive rate from select code
  logic       next_ok;    // code is supported
  logic [4:0] sel;        // five-bit select field

  assign sel = cfg.proto[P_SEL_HI:0];

  // combinational decode of the select field
  always_comb begin
    next_fam = FAM_NONE;
    next_rx  = ppcr_rate_t'(sel[1:0]);
    next_ok  = 1'b1;
    if (sel[4:2] == SEL_A_PFX) begin
      next_fam = FAM_A;
    end else if (sel[4:2] == SEL_B_PFX) begin
      next_fam = FAM_B;
    end else if (sel == SEL_V_212) begin
      next_fam = FAM_VEND;
      next_rx  = RATE_212;
    end else if (sel == SEL_V_424) begin
      next_fam = FAM_VEND;
      next_rx  = RATE_424;
    end else begin
      next_ok  = 1'b0;
      next_rx  = RATE_106;
    end
  end

  // decoded settings held in flops
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg.fam     <= FAM_NONE;
      cfg.rx_rate <= RATE_106;
      cfg.sel_ok  <= 1'b0;
    end else begin
      cfg.fam     <= next_fam;
      cfg.rx_rate <= next_rx;
      cfg.sel_ok  <= next_ok;
    end
  end

  // split rate only for type a or b, else follow receive
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg.tx_rate <= RATE_106;
    end else if (cfg.txa[A_SPLIT] &&
                 (next_fam == FAM_A || next_fam == FAM_B)) begin
      cfg.tx_rate <= ppcr_rate_t'(cfg.txa[A_RATE_HI:A_RATE_LO]);
    end else begin
      cfg.tx_rate <= next_rx;
    end
  end
endmodule // ppcr_decode

/* hw/ppcr_pkg.sv */
// package: map, field positions, defaults and timings of the config bank
package ppcr_pkg;
  // register offsets on the host register port
  localparam logic [4:0] ADR_PROTO = 5'h01;
  localparam logic [4:0] ADR_TXB   = 5'h02;
  localparam logic [4:0] ADR_TXA   = 5'h03;
  // values taken at reset or while the enable pin is low
  localparam logic [7:0] RST_PROTO = 8'h02;
  localparam logic [7:0] RST_TXB   = 8'h00;
  localparam logic [7:0] RST_TXA   = 8'h00;
  // implemented bits; unused bits read zero
  localparam logic [7:0] MASK_TXB  = 8'hfe;
  localparam logic [7:0] MASK_TXA  = 8'hf8;
  // protocol control fields
  localparam int P_NOCRC   = 7;
  localparam int P_DIR     = 6;
  localparam int P_SEL_HI  = 4;
  // type-b transmit option fields
  localparam int B_GT_HI   = 7;
  localparam int B_GT_LO   = 5;
  localparam int B_EOFL    = 4;
  localparam int B_SOFH    = 3;
  localparam int B_SOFL    = 2;
  localparam int B_LGT     = 1;
  // type-a rate and parity fields
  localparam int A_SPLIT   = 7;
  localparam int A_RATE_HI = 6;
  localparam int A_RATE_LO = 5;
  localparam int A_PTX     = 4;
  localparam int A_PRX     = 3;
  // protocol select codes
  localparam logic [2:0] SEL_A_PFX = 3'h2;
  localparam logic [2:0] SEL_B_PFX = 3'h3;
  localparam logic [4:0] SEL_V_212 = 5'h1a;
  localparam logic [4:0] SEL_V_424 = 5'h1b;
  // frame phase lengths in elementary time units
  localparam logic [3:0] ETU_LOW_LONG   = 4'hb;
  localparam logic [3:0] ETU_LOW_SHORT  = 4'ha;
  localparam logic [1:0] ETU_HIGH_LONG  = 2'h3;
  localparam logic [1:0] ETU_HIGH_SHORT = 2'h2;
  // air bit rates
  typedef enum logic [1:0] {
    RATE_106 = 2'b00,
    RATE_212 = 2'b01,
    RATE_424 = 2'b10,
    RATE_848 = 2'b11
  } ppcr_rate_t;
  // protocol family chosen by the select field
  typedef enum logic [1:0] {
    FAM_NONE = 2'b00,
    FAM_A    = 2'b01,
    FAM_B    = 2'b10,
    FAM_VEND = 2'b11
  } ppcr_fam_t;
endpackage

/* hw/ppcr_top.sv */
// module: protocol select and subsetting register bank with decode
`timescale 1ns/100ps
module ppcr_top (
  input  wire logic                SYS_CLK,
  input  wire logic                RSTN,
  input  wire logic                EN,
  input  wire logic [4:0]          REG_ADDR,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire logic [7:0]          REG_WDATA,
  output logic      [7:0]          REG_RDATA,
  output logic                     RX_CRC_CHECK,
  output logic                     DIRECT_MODE1,
  output ppcr_pkg::ppcr_fam_t      RX_FAMILY,
  output ppcr_pkg::ppcr_rate_t     RX_RATE,
  output logic                     SEL_SUPPORTED,
  output ppcr_pkg::ppcr_rate_t     TX_RATE,
  output logic      [2:0]          GUARD_ETU,
  output logic      [3:0]          EOF_LOW_ETU,
  output logic      [1:0]          SOF_HIGH_ETU,
  output logic      [3:0]          SOF_LOW_ETU,
  output logic                     GUARD_AFTER_LAST,
  input  wire logic                TXP_REQ,
  input  wire logic [7:0]          TXP_DATA,
  input  wire logic                TXP_LAST,
  output logic                     TXP_BIT,
  input  wire logic                RXP_REQ,
  input  wire logic [7:0]          RXP_DATA,
  input  wire logic                RXP_BIT,
  input  wire logic                RXP_LAST,
  output logic                     RXP_ERR
);
  import ppcr_pkg::*;

  logic [7:0] proto;      // protocol control register
  logic [7:0] txb;        // type-b transmit options
  logic [7:0] txa;        // type-a rate and parity options
  logic       wr_proto;   // host write to protocol control
  logic       wr_txb;     // host write to type-b options
  logic       wr_txa;     // host write to type-a options
  logic [7:0] next_rdata; // read mux result
  logic       alt_tx;     // alternate send parity active
  logic       alt_rx;     // alternate receive parity active
  logic       want_even;  // expected parity sense this byte
  logic       chk_even;   // checked parity sense this byte

  ppcr_cfg_if cfg ();     // link to the decoder

  // address decode of host writes
  assign wr_proto = REG_WR && (REG_ADDR == ADR_PROTO);
  assign wr_txb   = REG_WR && (REG_ADDR == ADR_TXB);
  assign wr_txa   = REG_WR && (REG_ADDR == ADR_TXA);

  // protocol control; enable low forces default
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      proto <= RST_PROTO;
    end else if (!EN) begin
      proto <= RST_PROTO;
    end else if (wr_proto) begin
      // reserved reader-mode bit stored as written
      proto <= REG_WDATA;
    end
  end

  // type-b transmit options
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      txb <= RST_TXB;
    end else if (!EN) begin
      txb <= RST_TXB;
    end else if (wr_txb) begin
      txb <= REG_WDATA & MASK_TXB;
    end
  end

  // type-a options; any control write clears them
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      txa <= RST_TXA;
    end else if (!EN || wr_proto) begin
      txa <= RST_TXA;
    end else if (wr_txa) begin
      // host uses this to set a differing send rate
      txa <= REG_WDATA & MASK_TXA;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (REG_ADDR)
      ADR_PROTO: next_rdata = proto;
      ADR_TXB:   next_rdata = txb;
      ADR_TXA:   next_rdata = txa;
      default:   next_rdata = 8'h00;
    endcase
  end

  // read data captured on the read strobe
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // hand register bytes to the decoder
  assign cfg.proto = proto;
  assign cfg.txa   = txa;

  ppcr_decode u_decode (
    .SYS_CLK (SYS_CLK),
    .RSTN    (RSTN),
    .cfg     (cfg)
  );

  // decoded protocol settings to the pins
  assign RX_FAMILY     = cfg.fam;
  assign RX_RATE       = cfg.rx_rate;
  assign SEL_SUPPORTED = cfg.sel_ok;
  assign TX_RATE       = cfg.tx_rate;

  // receive crc and direct mode variant flops
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_CRC_CHECK <= 1'b1;
      DIRECT_MODE1 <= 1'b0;
    end else begin
      RX_CRC_CHECK <= !proto[P_NOCRC];
      DIRECT_MODE1 <= proto[P_DIR];
    end
  end

  // type-b framing lengths for the encoder
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      GUARD_ETU        <= 3'h0;
      EOF_LOW_ETU      <= ETU_LOW_SHORT;
      SOF_HIGH_ETU     <= ETU_HIGH_SHORT;
      SOF_LOW_ETU      <= ETU_LOW_SHORT;
      GUARD_AFTER_LAST <= 1'b0;
    end else begin
      GUARD_ETU <= txb[B_GT_HI:B_GT_LO];
      // end-frame low phase length
      EOF_LOW_ETU <= txb[B_EOFL] ? ETU_LOW_LONG
                                 : ETU_LOW_SHORT;
      // start-frame high phase length
      SOF_HIGH_ETU <= txb[B_SOFH] ? ETU_HIGH_LONG
                                  : ETU_HIGH_SHORT;
      // start-frame low phase length
      SOF_LOW_ETU <= txb[B_SOFL] ? ETU_LOW_LONG
                                 : ETU_LOW_SHORT;
      GUARD_AFTER_LAST <= txb[B_LGT];
    end
  end

  // alternate parity only while type a is selected
  assign alt_tx    = txa[A_PTX] && (cfg.fam == FAM_A);
  assign alt_rx    = txa[A_PRX] && (cfg.fam == FAM_A);
  assign want_even = alt_tx && TXP_LAST;
  assign chk_even  = alt_rx && RXP_LAST;

  // send parity bit: odd normally, even on last byte while alternate send parity is active
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TXP_BIT <= 1'b0;
    end else if (TXP_REQ) begin
      TXP_BIT <= want_even ? (^TXP_DATA) : !(^TXP_DATA);
    end
  end

  // receive parity check, held until next byte
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RXP_ERR <= 1'b0;
    end else if (RXP_REQ) begin
      // even total when checking even, odd otherwise
      RXP_ERR <= (^{RXP_DATA, RXP_BIT}) == chk_even;
    end
  end

  // host write and enable sequences watched by the checks below
  sequence seq_wr_proto;
    EN && wr_proto;
  endsequence

  sequence seq_wr_txb;
    EN && wr_txb;
  endsequence

  sequence seq_stable_en;
    EN [*2];
  endsequence

  AST_NO_CRC: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 REG_WDATA[P_NOCRC] ##0 seq_stable_en
      |-> ##1 !RX_CRC_CHECK
  ) else $error("crc expected though no-crc bit set");

  // crc bit clear: checking stays on
  AST_CRC_ON: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 !REG_WDATA[P_NOCRC] ##0 seq_stable_en
      |-> ##1 RX_CRC_CHECK
  ) else $error("crc not expected though no-crc bit clear");

  AST_DIR_MODE: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 seq_stable_en
      |-> ##1 DIRECT_MODE1 == $past(REG_WDATA[P_DIR], 2)
  ) else $error("direct mode variant not following write");

  AST_TYPE_A: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 (REG_WDATA[4:2] == SEL_A_PFX)
      ##0 seq_stable_en
      |-> ##1 RX_FAMILY == FAM_A &&
          RX_RATE == ppcr_rate_t'($past(REG_WDATA[1:0], 2))
  ) else $error("type a select decoded wrongly");

  AST_TYPE_B: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 (REG_WDATA[4:2] == SEL_B_PFX)
      ##0 seq_stable_en
      |-> ##1 RX_FAMILY == FAM_B &&
          RX_RATE == ppcr_rate_t'($past(REG_WDATA[1:0], 2))
  ) else $error("type b select decoded wrongly");

  AST_VENDOR: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 (REG_WDATA[4:0] == SEL_V_424)
      ##0 seq_stable_en
      |-> ##1 RX_FAMILY == FAM_VEND && RX_RATE == RATE_424
  ) else $error("vendor select decoded wrongly");

  // vendor protocol at the lower rate
  AST_VEND_212: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 (REG_WDATA[4:0] == SEL_V_212)
      ##0 seq_stable_en
      |-> ##1 RX_FAMILY == FAM_VEND && RX_RATE == RATE_212
  ) else $error("vendor low rate select decoded wrongly");

  // codes 111xx are not among the supported ones
  AST_UNSUP: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_proto ##0 (REG_WDATA[4:2] == 3'h7) ##0 seq_stable_en
      |-> ##1 !SEL_SUPPORTED && RX_FAMILY == FAM_NONE
  ) else $error("unsupported select code accepted");

  AST_B_CLEAR: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    !EN |=> txb == RST_TXB
  ) else $error("type b options not cleared by enable");

  AST_GUARD: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 seq_stable_en
      |-> ##1 GUARD_ETU == $past(REG_WDATA[B_GT_HI:B_GT_LO], 2)
  ) else $error("guard time not following write");

  AST_EOF_LEN: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 REG_WDATA[B_EOFL] ##0 seq_stable_en
      |-> ##1 EOF_LOW_ETU == ETU_LOW_LONG
  ) else $error("end frame low phase not 11 etu");

  // short end-frame low phase
  AST_EOF_SHORT: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 !REG_WDATA[B_EOFL] ##0 seq_stable_en
      |-> ##1 EOF_LOW_ETU == ETU_LOW_SHORT
  ) else $error("end frame low phase not 10 etu");

  AST_SOF_HIGH: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 !REG_WDATA[B_SOFH] ##0 seq_stable_en
      |-> ##1 SOF_HIGH_ETU == ETU_HIGH_SHORT
  ) else $error("start frame high phase not 2 etu");

  // long start-frame high phase
  AST_SOF_HIGH_LONG: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 REG_WDATA[B_SOFH] ##0 seq_stable_en
      |-> ##1 SOF_HIGH_ETU == ETU_HIGH_LONG
  ) else $error("start frame high phase not 3 etu");

  AST_SOF_LOW: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 !REG_WDATA[B_SOFL] ##0 seq_stable_en
      |-> ##1 SOF_LOW_ETU == ETU_LOW_SHORT
  ) else $error("start frame low phase not 10 etu");

  // long start-frame low phase
  AST_SOF_LOW_LONG: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 REG_WDATA[B_SOFL] ##0 seq_stable_en
      |-> ##1 SOF_LOW_ETU == ETU_LOW_LONG
  ) else $error("start frame low phase not 11 etu");

  AST_LAST_GUARD: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    seq_wr_txb ##0 seq_stable_en
      |-> ##1 GUARD_AFTER_LAST == $past(REG_WDATA[B_LGT], 2)
  ) else $error("final guard flag not following write");

  AST_SPLIT: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (!txa[A_SPLIT] && $stable(proto)) |=> TX_RATE == RX_RATE
  ) else $error("send rate differs without split enable");

  // split enabled on type a or b: rate field drives send
  AST_TX_SPLIT: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    txa[A_SPLIT] && $stable(proto) &&
      (RX_FAMILY == FAM_A || RX_FAMILY == FAM_B)
      |=> TX_RATE == ppcr_rate_t'($past(txa[A_RATE_HI:A_RATE_LO]))
  ) else $error("send rate not taken from split field");

  AST_PAR_TX: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    TXP_REQ && alt_tx && TXP_LAST |=> TXP_BIT == $past(^TXP_DATA)
  ) else $error("last byte send parity not even");

  AST_PAR_RX: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    RXP_REQ && !alt_rx && (^{RXP_DATA, RXP_BIT}) |=> !RXP_ERR
  ) else $error("odd parity byte flagged as error");

  AST_A_CLEAR: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    wr_proto |=> txa == RST_TXA
  ) else $error("type a options kept over control write");

  AST_PROTO_RST: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    !EN |=> proto == RST_PROTO
  ) else $error("protocol control not at default");
endmodule // ppcr_top

/* verif/ppcr_host.sv */
// host model: register port master of the config bank
`timescale 1ns/100ps
module ppcr_host (
  input  wire logic       clk,
  output logic      [4:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  import ppcr_pkg::*;
  // idle bus at time zero
  initial begin
    addr  = 5'h1f;
    wr    = 1'b0;
    rd    = 1'b0;
    wdata = 8'h55;
  end
  // one write strobe; lines scrambled after release
  task automatic wrb(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    // reader-mode bit never set by this host
    if (a == ADR_PROTO) d[5] = 1'b0;
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask
  // one read strobe; data taken after the read edge
  task automatic rdb(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    addr = ~a;
    d    = rdata;
  endtask
  // protocol first: its write clears the options byte
  task automatic cfg(input logic [7:0] p, input logic [7:0] o);
    wrb(ADR_PROTO, p);
    wrb(ADR_TXA, o);
  endtask
endmodule // ppcr_host

/* verif/ppcr_top_bench.sv */
// testbench: register bank, decode and parity of the config block
`timescale 1ns/100ps
module ppcr_top_bench;
  import ppcr_pkg::*;
  // one row: control byte and its decode
  typedef struct packed {
    logic [7:0] p;
    ppcr_fam_t  f;
    ppcr_rate_t r;
    logic       s;
  } ppcr_row_t;
  logic       clk = 0, rstn = 0, en = 1;  // clock, reset, enable
  logic [4:0] addr;                       // host bus
  logic       wr, rd;
  logic [7:0] wdata, rdata, v;
  logic       crc, dir1, sup, gal;        // decoded flags
  ppcr_fam_t  fam;
  ppcr_rate_t rxr, txr;
  logic [2:0] gt;                         // frame timing
  logic [3:0] eofl, sofl;
  logic [1:0] sofh;
  logic       tq = 0, tl = 0, tb;         // parity ports
  logic       rq = 0, rl = 0, rb = 0, re;
  logic [7:0] td = 0, rdd = 0;
  int         n_errors = 0, n_tests = 0;
  ppcr_row_t  rows [11] = '{
    '{8'h08, FAM_A, RATE_106, 1'b1}, '{8'h89, FAM_A, RATE_212, 1'b1},
    '{8'h4a, FAM_A, RATE_424, 1'b1}, '{8'h0b, FAM_A, RATE_848, 1'b1},
    '{8'h0c, FAM_B, RATE_106, 1'b1}, '{8'hcd, FAM_B, RATE_212, 1'b1},
    '{8'h0e, FAM_B, RATE_424, 1'b1}, '{8'h0f, FAM_B, RATE_848, 1'b1},
    '{8'h1a, FAM_VEND, RATE_212, 1'b1}, '{8'h9b, FAM_VEND, RATE_424, 1'b1},
    '{8'h1c, FAM_NONE, RATE_106, 1'b0}};
  logic [7:0] bv [4] = '{8'hff, 8'h35, 8'h4a, 8'h01};  // options bytes
  // 100 MHz clock
  always #5 clk = ~clk;
  ppcr_top DUT (.SYS_CLK(clk), .RSTN(rstn), .EN(en), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .RX_CRC_CHECK(crc), .DIRECT_MODE1(dir1), .RX_FAMILY(fam),
    .RX_RATE(rxr), .SEL_SUPPORTED(sup), .TX_RATE(txr), .GUARD_ETU(gt),
    .EOF_LOW_ETU(eofl), .SOF_HIGH_ETU(sofh), .SOF_LOW_ETU(sofl),
    .GUARD_AFTER_LAST(gal), .TXP_REQ(tq), .TXP_DATA(td), .TXP_LAST(tl),
    .TXP_BIT(tb), .RXP_REQ(rq), .RXP_DATA(rdd), .RXP_BIT(rb),
    .RXP_LAST(rl), .RXP_ERR(re));
  ppcr_host h (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .rdata(rdata));
  // compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("counts: tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one parity request on both paths
  task automatic par(input logic [7:0] d, input logic l, et, ee);
    @(negedge clk);
    tq  = 1'b1;
    td  = d;
    tl  = l;
    rq  = 1'b1;
    rdd = d;
    rl  = l;
    @(negedge clk);
    tq  = 1'b0;
    rq  = 1'b0;
    td  = ~d;
    rdd = ~d;
    chk(tb, et);
    chk(re, ee);
  endtask
  // three registers read back at default
  task automatic defaults;
    h.rdb(ADR_PROTO, v);
    chk(v, 8'h02);
    h.rdb(ADR_TXB, v);
    chk(v, 8'h00);
    h.rdb(ADR_TXA, v);
    chk(v, 8'h00);
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    defaults;
    chk(crc, 1'b1);
    $display("reset test done");
    foreach (rows[i]) begin
      h.cfg(rows[i].p, 8'h00);
      h.rdb(ADR_PROTO, v);
      chk(v, rows[i].p);
      chk(fam, rows[i].f);
      chk(rxr, rows[i].r);
      chk(sup, rows[i].s);
      chk(crc, !rows[i].p[7]);
      chk(dir1, rows[i].p[6]);
      chk(txr, rows[i].r);
    end
    $display("select table done");
    foreach (bv[i]) begin
      h.wrb(ADR_TXB, bv[i]);
      h.rdb(ADR_TXB, v);
      chk(v, bv[i] & 8'hfe);
      chk(gt, bv[i][7:5]);
      chk(eofl, bv[i][4] ? 4'hb : 4'ha);
      chk(sofh, bv[i][3] ? 2'h3 : 2'h2);
      chk(sofl, bv[i][2] ? 4'hb : 4'ha);
      chk(gal, bv[i][1]);
    end
    $display("type-b options done");
    for (int r = 0; r < 4; r++) begin
      h.cfg(8'h0b, {1'b1, r[1:0], 5'h1f});
      h.rdb(ADR_TXA, v);
      chk(v, {1'b1, r[1:0], 5'h18});
      chk(txr, r[1:0]);
    end
    h.cfg(8'h08, 8'h60);
    h.rdb(ADR_TXA, v);
    chk(v, 8'h60);
    chk(txr, RATE_106);
    h.cfg(8'h1a, 8'he0);
    h.rdb(ADR_TXA, v);
    chk(txr, RATE_212);
    h.wrb(ADR_PROTO, 8'h0c);
    h.rdb(ADR_TXA, v);
    chk(v, 8'h00);
    chk(txr, RATE_106);
    $display("rate tests done");
    h.cfg(8'h08, 8'h18);
    par(8'h01, 1'b0, 1'b0, 1'b0);
    par(8'h01, 1'b1, 1'b1, 1'b1);
    par(8'h03, 1'b1, 1'b0, 1'b0);
    par(8'h03, 1'b0, 1'b1, 1'b1);
    rb = 1'b1;
    par(8'h01, 1'b1, 1'b1, 1'b0);
    rb = 1'b0;
    h.cfg(8'h0c, 8'h18);
    par(8'h01, 1'b1, 1'b0, 1'b0);
    $display("parity tests done");
    h.wrb(ADR_TXB, 8'hfe);
    h.cfg(8'h89, 8'h18);
    @(negedge clk);
    en = 1'b0;
    h.wrb(ADR_TXB, 8'h10);
    @(negedge clk);
    en = 1'b1;
    defaults;
    h.rdb(5'h04, v);
    chk(v, 8'h00);
    h.wrb(5'h1f, 8'hff);
    h.rdb(5'h1f, v);
    chk(v, 8'h00);
    $display("enable and map tests done");
    h.cfg(8'h89, 8'h18);
    h.wrb(ADR_TXB, 8'hfe);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk(crc, 1'b1);
    chk(gt, 3'h0);
    rstn = 1'b1;
    defaults;
    $display("mid-run reset done");
    test_done;
  end
endmodule // ppcr_top_bench
